// ### verilog/psmc_top.sv
// power-saving mode controller: wait, active-halt and halt entry and exit
// assumes the cpu presents each executed opcode for one cycle with instrValid,
// the cpu stacks the condition code itself and returns the popped level bits
//
// Functional notes
// - wait-for-interrupt stops the cpu; peripherals keep running in wait
// - entering wait forces interrupt-level bits to binary 10
// - wait changes no other register or memory
// - wait ends on any interrupt or reset, then jumps to its routine
// - servicing pushes condition code, sets level to priority, pop restores it
// - halt enters halt if interrupt-enable bit is 0, active-halt if 1
// - active-halt wakes only on timebase, designated interrupts, or reset
// - active-halt interrupt exit skips the 4096-cycle delay; reset exit keeps it
// - entering active-halt forces level 10; pending interrupt wakes at once
// - active-halt keeps only oscillator and timebase clocked
// - with interrupt-enable set, active-halt never causes a watchdog reset
// - halt wakes on designated interrupts or reset, after 4096 cycles
// - entering halt forces level 10; pending interrupt wakes at once
// - halt turns the oscillator off, stopping all internal clocks
// - non-volatile option decides whether halt with watchdog gives reset
// - the decoder recognises byte 0x8E as the halt instruction
`timescale 1ns/1ps
module psmc_top (
  input  wire logic                                  core_clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  instrValid,
  input  wire logic [7:0]                            instrOpcode,
  input  wire logic                                  oscillator_interrupt_enable,
  input  wire logic                                  watchdog_halt_option,
  input  wire logic                                  watchdogEnabled,
  input  wire logic                                  resetReq,
  input  wire logic [psmc_pkg::NUM_IRQ-1:0]          irqReq,
  input  wire logic [psmc_pkg::NUM_IRQ*psmc_pkg::LVL_W-1:0] irqPriority,
  input  wire logic                                  ccPopValid,
  input  wire logic [psmc_pkg::LVL_W-1:0]            ccPopLevel,
  output psmc_pkg::psmc_mode_e                       modeState,
  output logic                                       cpuClkEn,
  output logic                                       periphClkEn,
  output logic                                       timebaseClkEn,
  output logic                                       oscEnable,
  output logic [psmc_pkg::LVL_W-1:0]                 ccIntLevel,
  output logic                                       ccPush,
  output logic                                       serviceStart,
  output logic [psmc_pkg::IRQ_IDX_W-1:0]             serviceVector,
  output logic                                       fetchResetVector,
  output logic                                       watchdogResetReq
);
  import psmc_pkg::*;

  // ************************************************************
  // internal signals
  // ************************************************************
  psmc_mode_e             mode;
  psmc_mode_e             next_mode;
  logic                   wakeByReset;
  logic                   anyIrq;
  logic                   haltWake;
  logic                   activeHaltWake;
  logic [IRQ_IDX_W-1:0]   topIdx;
  logic                   stabStart;
  logic                   stabBusy;
  logic                   stabDone;
  logic                   isHalt;
  logic                   isWfi;
  logic                   haltWdgReset;
  logic                   goService;
  logic                   goResetFetch;
  logic                   entering;
  logic [NUM_IRQ-1:0]     wakeMask;
  logic [NUM_IRQ-1:0]     wakeReq;

  assign modeState = mode;

  // ************************************************************
  // wake request masking
  // ************************************************************
  // in the halt modes only a legal wake source is serviced first, so an
  // unrelated pending request cannot take the place of the wake-up routine
  always_comb begin
    wakeMask = '1;
    case (mode)
      MODE_ACTIVE_HALT: begin
        wakeMask               = HALT_WAKE_MASK;
        wakeMask[TIMEBASE_IRQ] = 1'b1;
      end
      MODE_HALT, MODE_STABILISE: begin
        wakeMask = HALT_WAKE_MASK;
      end
      default: begin
        wakeMask = '1;
      end
    endcase
  end

  // requests seen by the filter; wait accepts them all
  assign wakeReq = irqReq & wakeMask;

  // ************************************************************
  // wake filter and stabilisation counter
  // ************************************************************
  psmc_wake_filter u_wake (
    .irqReq         (wakeReq),
    .anyIrq         (anyIrq),
    .haltWake       (haltWake),
    .activeHaltWake (activeHaltWake),
    .topIdx         (topIdx)
  );

  psmc_stab_counter u_stab (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (stabStart),
    .busy     (stabBusy),
    .done     (stabDone)
  );

  // ************************************************************
  // instruction decode
  // ************************************************************
  // only opcodes executed in run count
  assign isHalt = (mode == MODE_RUN) && instrValid && (instrOpcode == HALT_OPCODE);
  assign isWfi  = (mode == MODE_RUN) && instrValid && (instrOpcode == WFI_OPCODE);
  // plain halt with a running watchdog that does not tolerate it resets
  assign haltWdgReset = isHalt && !oscillator_interrupt_enable
                        && watchdogEnabled && !watchdog_halt_option;

  // ************************************************************
  // mode sequencing
  // ************************************************************
  // next mode and the wake actions taken on the same edge
  always_comb begin
    next_mode    = mode;
    stabStart    = 1'b0;
    goService    = 1'b0;
    goResetFetch = 1'b0;
    case (mode)
      MODE_RUN: begin
        if (isWfi) begin
          next_mode = MODE_WAIT;
        end else if (isHalt && oscillator_interrupt_enable) begin
          next_mode = MODE_ACTIVE_HALT;
        end else if (isHalt && !haltWdgReset) begin
          next_mode = MODE_HALT;
        end
      end
      MODE_WAIT: begin
        // any interrupt or reset ends wait, straight to the routine
        if (resetReq) begin
          next_mode    = MODE_RUN;
          goResetFetch = 1'b1;
        end else if (anyIrq) begin
          next_mode = MODE_RUN;
          goService = 1'b1;
        end
      end
      MODE_ACTIVE_HALT: begin
        // reset exit pays the delay, interrupt exit does not
        if (resetReq) begin
          next_mode = MODE_STABILISE;
          stabStart = 1'b1;
        end else if (activeHaltWake) begin
          next_mode = MODE_RUN;
          goService = 1'b1;
        end
      end
      MODE_HALT: begin
        // oscillator restarts on any legal wake source
        if (resetReq || haltWake) begin
          next_mode = MODE_STABILISE;
          stabStart = 1'b1;
        end
      end
      MODE_STABILISE: begin
        if (stabDone) begin
          next_mode    = MODE_RUN;
          goResetFetch = wakeByReset;
          goService    = !wakeByReset;
        end
      end
      default: begin
        next_mode = MODE_RUN;
      end
    endcase
  end

  // mode register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // remember whether the delay was started by a reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wakeByReset <= 1'b0;
    end else if (stabStart) begin
      wakeByReset <= resetReq;
    end
  end

  // ************************************************************
  // clock gating
  // ************************************************************
  // gates follow next_mode so they line up with modeState
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpuClkEn      <= 1'b1;
      periphClkEn   <= 1'b1;
      timebaseClkEn <= 1'b1;
      oscEnable     <= 1'b1;
    end else begin
      cpuClkEn      <= (next_mode == MODE_RUN);
      periphClkEn   <= (next_mode == MODE_RUN) || (next_mode == MODE_WAIT);
      timebaseClkEn <= (next_mode != MODE_HALT) && (next_mode != MODE_STABILISE);
      oscEnable     <= (next_mode != MODE_HALT);
    end
  end

  // ************************************************************
  // interrupt level bits
  // ************************************************************
  assign entering = (next_mode == MODE_WAIT) || (next_mode == MODE_HALT)
                    || (next_mode == MODE_ACTIVE_HALT);

  // only the level bits are touched; nothing else is altered
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ccIntLevel <= LVL_RESET;
    end else if (goResetFetch) begin
      ccIntLevel <= LVL_RESET;
    end else if (goService) begin
      ccIntLevel <= irqPriority[topIdx*LVL_W +: LVL_W];
    end else if ((mode == MODE_RUN) && entering) begin
      ccIntLevel <= LVL_ALL_ENABLED;
    end else if (ccPopValid) begin
      ccIntLevel <= ccPopLevel;
    end
  end

  // ************************************************************
  // wake actions toward the cpu
  // ************************************************************
  // one-cycle pulses, vector held until the next service
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ccPush           <= 1'b0;
      serviceStart     <= 1'b0;
      fetchResetVector <= 1'b0;
    end else begin
      ccPush           <= goService;
      serviceStart     <= goService;
      fetchResetVector <= goResetFetch;
    end
  end

  // vector of the serviced interrupt
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      serviceVector <= '0;
    end else if (goService) begin
      serviceVector <= topIdx;
    end
  end

  // watchdog reset request when halt is not tolerated
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      watchdogResetReq <= 1'b0;
    end else begin
      watchdogResetReq <= haltWdgReset;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [STAB_CNT_W:0] stabLen;

  // helper: cycles spent in stabilise
  always_ff @(posedge core_clk) begin
    if (sys_rst || (mode != MODE_STABILISE)) begin
      stabLen <= '0;
    end else begin
      stabLen <= stabLen + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  wait_entry_a: assert property (
    isWfi |=> (mode == MODE_WAIT) && (ccIntLevel == LVL_ALL_ENABLED))
    else $error("wait entry or level force wrong");

  wait_clocks_a: assert property (
    (mode == MODE_WAIT) |-> periphClkEn && !cpuClkEn)
    else $error("wait clock gating wrong");

  wait_wake_a: assert property (
    (mode == MODE_WAIT) && anyIrq && !resetReq |=> serviceStart && (mode == MODE_RUN))
    else $error("wait did not wake on interrupt");

  mode_select_a: assert property (
    isHalt && !isWfi |=> (mode == ($past(oscillator_interrupt_enable) ?
      MODE_ACTIVE_HALT : ($past(haltWdgReset) ? MODE_RUN : MODE_HALT))))
    else $error("halt mode selection wrong");

  ahalt_fast_a: assert property (
    (mode == MODE_ACTIVE_HALT) && activeHaltWake && !resetReq
      |=> serviceStart && ccPush && cpuClkEn)
    else $error("active-halt interrupt exit delayed");

  ahalt_block_a: assert property (
    (mode == MODE_ACTIVE_HALT) && !activeHaltWake && !resetReq |=> (mode == MODE_ACTIVE_HALT))
    else $error("active-halt left without wake source");

  ahalt_clocks_a: assert property (
    (mode == MODE_ACTIVE_HALT) |-> oscEnable && timebaseClkEn && !periphClkEn && !cpuClkEn)
    else $error("active-halt clock gating wrong");

  halt_osc_a: assert property (
    (mode == MODE_HALT) |-> !oscEnable && !periphClkEn && !timebaseClkEn)
    else $error("halt left a clock running");

  stab_len_a: assert property (
    (mode == MODE_STABILISE) && (next_mode == MODE_RUN) |-> (stabLen == STAB_LAST))
    else $error("stabilisation length wrong");

  halt_wake_a: assert property (
    (mode == MODE_HALT) && haltWake |=> (mode == MODE_STABILISE) && oscEnable)
    else $error("halt wake did not restart oscillator");

  wdg_quiet_a: assert property (
    isHalt && oscillator_interrupt_enable |=> !watchdogResetReq)
    else $error("watchdog reset from active-halt entry");

  ahalt_vector_a: assert property (
    (mode == MODE_ACTIVE_HALT) && activeHaltWake && !resetReq
      |=> HALT_WAKE_MASK[serviceVector] || (serviceVector == TIMEBASE_IRQ))
    else $error("active-halt serviced a non-wake vector");

  pop_restore_a: assert property (
    ccPopValid && (mode == MODE_RUN) && (next_mode == MODE_RUN)
      |=> (ccIntLevel == $past(ccPopLevel)))
    else $error("popped level not restored");

  wait_wake_c: cover property ((mode == MODE_WAIT) ##1 serviceStart);
  ahalt_wake_c: cover property ((mode == MODE_ACTIVE_HALT) ##1 serviceStart);
  halt_stab_c: cover property ((mode == MODE_STABILISE) && stabDone);
  wdg_reset_c: cover property (watchdogResetReq);

endmodule : psmc_top

// ### include/psmc_pkg.sv
// power-saving mode controller: shared constants and the mode enumeration
// assumes one core clock equal to the cpu clock; no software-visible registers
package psmc_pkg;

  // ************************************************************
  // instruction decode
  // ************************************************************
  localparam logic [7:0] HALT_OPCODE = 8'h8E;
  localparam logic [7:0] WFI_OPCODE  = 8'h8F;   // plain default, set per core

  // ************************************************************
  // interrupt vectors
  // ************************************************************
  localparam int          NUM_IRQ        = 14;
  localparam int          IRQ_IDX_W      = 4;
  localparam int          TIMEBASE_IRQ   = 5;
  // vectors allowed to end halt: ext 0, ext 1, serial, timebase
  localparam logic [13:0] HALT_WAKE_MASK = 14'h002B;
  localparam logic [13:0] NO_IRQ         = 14'h0000;

  // ************************************************************
  // interrupt level bits
  // ************************************************************
  localparam int         LVL_W           = 2;
  localparam logic [1:0] LVL_ALL_ENABLED = 2'h2;
  localparam logic [1:0] LVL_RESET       = 2'h3;

  // ************************************************************
  // oscillator stabilisation
  // ************************************************************
  localparam int STAB_CYCLES = 4096;
  localparam int STAB_CNT_W  = $clog2(STAB_CYCLES);
  localparam logic [STAB_CNT_W-1:0] STAB_LAST = STAB_CNT_W'(STAB_CYCLES - 1);
  localparam logic [STAB_CNT_W-1:0] STAB_ZERO = '0;

  // ************************************************************
  // power modes
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_ACTIVE_HALT,
    MODE_HALT,
    MODE_STABILISE
  } psmc_mode_e;

endpackage : psmc_pkg

// ### verilog/psmc_stab_counter.sv
// oscillator stabilisation counter: counts exactly STAB_CYCLES cycles
// assumes start is a one-cycle pulse given while idle
`timescale 1ns/1ps
module psmc_stab_counter (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import psmc_pkg::*;

  logic [STAB_CNT_W-1:0] count;

  // busy from the start edge until the last counted cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (done) begin
      busy <= 1'b0;
    end
  end

  // cycle counter, cleared on start
  always_ff @(posedge core_clk) begin
    if (sys_rst || start) begin
      count <= STAB_ZERO;
    end else if (busy) begin
      count <= count + 1'b1;
    end
  end

  // done marks the last of the STAB_CYCLES busy cycles
  assign done = busy && (count == STAB_LAST);

endmodule : psmc_stab_counter

// ### verilog/psmc_wake_filter.sv
// wake-source filter: per-vector eligibility and lowest-index pending vector
// assumes irqReq are level requests already synchronous to the core clock
`timescale 1ns/1ps
module psmc_wake_filter (
  input  wire logic [psmc_pkg::NUM_IRQ-1:0]   irqReq,
  output logic                                anyIrq,
  output logic                                haltWake,
  output logic                                activeHaltWake,
  output logic [psmc_pkg::IRQ_IDX_W-1:0]      topIdx
);
  import psmc_pkg::*;

  logic [NUM_IRQ-1:0] haltOk;
  logic [NUM_IRQ-1:0] activeOk;

  // per vector: may it end halt, may it end active-halt
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_vec
    assign haltOk[i]   = irqReq[i] && HALT_WAKE_MASK[i];
    assign activeOk[i] = irqReq[i] && (HALT_WAKE_MASK[i] || (i == TIMEBASE_IRQ));
  end

  assign anyIrq         = |irqReq;
  assign haltWake       = |haltOk;
  assign activeHaltWake = |activeOk;

  // lowest index wins, matching the fixed hardware priority order
  always_comb begin
    topIdx = '0;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (irqReq[k]) begin
        topIdx = IRQ_IDX_W'(k);
      end
    end
  end

endmodule : psmc_wake_filter

// ### bench/psmc_cpu_model.sv
// cpu-side model: stacks the level bits on a push and hands them back on a pop
// assumes the bench asks for a pop with a one-cycle popReq set at a falling edge
`timescale 1ns/1ps
module psmc_cpu_model (
  input  wire logic                        core_clk,
  input  wire logic [psmc_pkg::LVL_W-1:0]  ccIntLevel,
  input  wire logic                        ccPush,
  input  wire logic                        popReq,
  output logic                             ccPopValid = 1'b0,
  output logic      [psmc_pkg::LVL_W-1:0]  ccPopLevel = 2'h0
);
  import psmc_pkg::*;
  // ************************************************************
  // stack and pop
  // ************************************************************
  logic [LVL_W-1:0] prevLvl = 2'h0;
  logic [LVL_W-1:0] stacked = 2'h0;
  logic             go      = 1'b0;
  // keep the level from before the push, since the push edge already moves it
  always @(posedge core_clk) begin
    prevLvl <= ccIntLevel;
    go      <= popReq;
    if (ccPush) begin
      stacked <= prevLvl;
    end
  end
  // pop just after a falling edge; data is scrambled outside the pulse
  always @(negedge core_clk) begin
    ccPopValid <= go;
    ccPopLevel <= go ? stacked : ~ccPopLevel;
  end
endmodule : psmc_cpu_model

// ### bench/psmc_top_tb.sv
// bench for the power-saving mode controller: wait, active-halt and halt
// assumes psmc_pkg and the design files are compiled first; 40 MHz core clock
`timescale 1ns/1ps
module psmc_top_tb;
  import psmc_pkg::*;
  // ************************************************************
  // stimulus, design and cpu model
  // ************************************************************
  logic                     core_clk                    = 1'b0;
  logic                     sys_rst                     = 1'b1;
  logic                     instrValid                  = 1'b0;
  logic [7:0]               instrOpcode                 = 8'h00;
  logic                     oscillator_interrupt_enable = 1'b0;
  logic                     watchdog_halt_option        = 1'b0;
  logic                     watchdogEnabled             = 1'b0;
  logic                     resetReq                    = 1'b0;
  logic [NUM_IRQ-1:0]       irqReq                      = NO_IRQ;
  logic [NUM_IRQ*LVL_W-1:0] irqPriority                 = 28'h0000101;
  logic                     popReq                      = 1'b0;
  logic                     ccPopValid;
  logic [LVL_W-1:0]         ccPopLevel;
  psmc_mode_e               modeState;
  logic                     cpuClkEn, periphClkEn, timebaseClkEn, oscEnable;
  logic [LVL_W-1:0]         ccIntLevel;
  logic                     ccPush, serviceStart, fetchResetVector, watchdogResetReq;
  logic [IRQ_IDX_W-1:0]     serviceVector;
  int                       bad_count = 0;
  int                       checked   = 0;

  // free-running core clock, 25 ns period
  always #12.5 core_clk = ~core_clk;

  psmc_top dut_u (.core_clk, .sys_rst, .instrValid, .instrOpcode,
    .oscillator_interrupt_enable, .watchdog_halt_option, .watchdogEnabled,
    .resetReq, .irqReq, .irqPriority, .ccPopValid, .ccPopLevel, .modeState,
    .cpuClkEn, .periphClkEn, .timebaseClkEn, .oscEnable, .ccIntLevel, .ccPush,
    .serviceStart, .serviceVector, .fetchResetVector, .watchdogResetReq);

  psmc_cpu_model cpu_u (.core_clk, .ccIntLevel, .ccPush, .popReq, .ccPopValid,
    .ccPopLevel);

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step

  // one executed opcode; outputs of its edge are settled on return
  task automatic exec(input logic [7:0] op);
    instrValid  = 1'b1;
    instrOpcode = op;
    step(1);
    instrValid  = 1'b0;
    instrOpcode = 8'h00;
  endtask : exec

  task automatic pop(input logic [LVL_W-1:0] exp);
    popReq = 1'b1;
    step(1);
    popReq = 1'b0;
    step(1);
    chk("popped level", ccIntLevel, exp);
  endtask : pop

  // first service cycle: branch, push and routine level
  task automatic svc(input logic [IRQ_IDX_W-1:0] vec, input logic [LVL_W-1:0] lvl);
    chk("serviceStart", serviceStart, 1'b1);
    chk("ccPush", ccPush, 1'b1);
    chk("serviceVector", serviceVector, vec);
    chk("service level", ccIntLevel, lvl);
    chk("cpuClkEn", cpuClkEn, 1'b1);
  endtask : svc

  // counts stabilisation cycles under a bound
  task automatic stab();
    int n;
    n = 0;
    while (modeState === MODE_STABILISE && n < 5000) begin
      n++;
      step(1);
    end
    if (n >= 5000) begin
      bad_count++;
      report_and_stop();
    end
    chk("stab cycles", n, STAB_CYCLES);
  endtask : stab

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk("mode", modeState, MODE_RUN);
    chk("clocks", {cpuClkEn, periphClkEn, timebaseClkEn, oscEnable}, 4'hF);
    chk("level", ccIntLevel, LVL_RESET);
    $display("test reset done");
  endtask : t_reset

  task automatic t_wait();
    exec(WFI_OPCODE);
    chk("mode", modeState, MODE_WAIT);
    chk("cpuClkEn", cpuClkEn, 1'b0);
    chk("periph clocks", {periphClkEn, timebaseClkEn}, 2'h3);
    chk("level", ccIntLevel, LVL_ALL_ENABLED);
    step(1);
    exec(HALT_OPCODE);
    chk("mode", modeState, MODE_WAIT);
    irqReq = 14'h0010;
    step(1);
    svc(4'h4, 2'h1);
    irqReq = NO_IRQ;
    step(1);
    chk("serviceStart", serviceStart, 1'b0);
    chk("mode", modeState, MODE_RUN);
    pop(LVL_ALL_ENABLED);
    $display("test wait done");
  endtask : t_wait

  task automatic t_active_halt();
    oscillator_interrupt_enable = 1'b1;
    watchdogEnabled = 1'b1;
    exec(HALT_OPCODE);
    chk("mode", modeState, MODE_ACTIVE_HALT);
    chk("level", ccIntLevel, LVL_ALL_ENABLED);
    chk("cpu periph", {cpuClkEn, periphClkEn}, 2'h0);
    chk("timebase osc", {timebaseClkEn, oscEnable}, 2'h3);
    irqReq = 14'h0010;
    step(3);
    chk("mode", modeState, MODE_ACTIVE_HALT);
    chk("watchdogResetReq", watchdogResetReq, 1'b0);
    irqReq = 14'h0030;
    step(1);
    svc(4'h5, 2'h0);
    chk("mode", modeState, MODE_RUN);
    irqReq = NO_IRQ;
    oscillator_interrupt_enable = 1'b0;
    watchdogEnabled = 1'b0;
    step(1);
    pop(LVL_ALL_ENABLED);
    $display("test active-halt done");
  endtask : t_active_halt

  task automatic t_halt_irq();
    irqReq = 14'h0001;
    exec(HALT_OPCODE);
    chk("mode", modeState, MODE_HALT);
    chk("osc timebase", {oscEnable, timebaseClkEn}, 2'h0);
    chk("cpu periph", {cpuClkEn, periphClkEn}, 2'h0);
    chk("level", ccIntLevel, LVL_ALL_ENABLED);
    step(1);
    chk("mode", modeState, MODE_STABILISE);
    chk("oscEnable", oscEnable, 1'b1);
    stab();
    svc(4'h0, 2'h1);
    irqReq = NO_IRQ;
    step(1);
    pop(LVL_ALL_ENABLED);
    $display("test halt done");
  endtask : t_halt_irq

  task automatic t_wdg();
    watchdogEnabled = 1'b1;
    exec(HALT_OPCODE);
    chk("watchdogResetReq", watchdogResetReq, 1'b1);
    chk("mode", modeState, MODE_RUN);
    step(1);
    chk("watchdogResetReq", watchdogResetReq, 1'b0);
    watchdog_halt_option = 1'b1;
    exec(HALT_OPCODE);
    chk("mode", modeState, MODE_HALT);
    chk("watchdogResetReq", watchdogResetReq, 1'b0);
    irqReq = 14'h0010;
    step(3);
    chk("mode", modeState, MODE_HALT);
    irqReq = NO_IRQ;
    resetReq = 1'b1;
    step(1);
    resetReq = 1'b0;
    chk("mode", modeState, MODE_STABILISE);
    stab();
    chk("fetchResetVector", fetchResetVector, 1'b1);
    chk("serviceStart", serviceStart, 1'b0);
    chk("level", ccIntLevel, LVL_RESET);
    watchdogEnabled = 1'b0;
    $display("test watchdog halt done");
  endtask : t_wdg

  task automatic t_wait_reset();
    exec(WFI_OPCODE);
    resetReq = 1'b1;
    step(1);
    resetReq = 1'b0;
    chk("mode", modeState, MODE_RUN);
    chk("fetchResetVector", fetchResetVector, 1'b1);
    chk("level", ccIntLevel, LVL_RESET);
    $display("test wait reset done");
  endtask : t_wait_reset

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    step(3);
    sys_rst = 1'b0;
    t_reset();
    t_wait();
    t_wait_reset();
    t_active_halt();
    t_wdg();
    t_halt_irq();
    report_and_stop();
  end
endmodule : psmc_top_tb
